// ===== iit_buf2.sv
/*
  Two-entry byte buffer with valid and ready on both sides.
  Assumes the clock enable freezes all state while low.
*/
`timescale 1ns/100ps
module iit_buf2 (
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  ce,
  iit_buf_if.buffer  bp
);
  logic [7:0] mem_reg [2];
  logic       wr_ptr_reg;
  logic       rd_ptr_reg;
  logic [1:0] cnt_reg;
  logic       push;
  logic       pop;

  assign bp.in_ready  = (cnt_reg != 2'h2);
  assign bp.out_valid = (cnt_reg != 2'h0);
  assign bp.out_data  = mem_reg[rd_ptr_reg];
  assign push = bp.in_valid && bp.in_ready;
  assign pop  = bp.out_valid && bp.out_ready;

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_reg[wr_ptr_reg] <= bp.in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg    <= 2'h0;
    end else if (ce) begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      cnt_reg <= 2'(cnt_reg + {1'b0, push} - {1'b0, pop});
    end
  end
endmodule

// ===== iit_buf_if.sv
/*
  Carrier for the two-entry byte buffer between the core and its engine.
  Assumes both sides share one clock.
*/
`timescale 1ns/100ps
interface iit_buf_if;
  logic [7:0] in_data;
  logic       in_valid;
  logic       in_ready;
  logic [7:0] out_data;
  logic       out_valid;
  logic       out_ready;
  modport buffer (input in_data, in_valid, out_ready, output in_ready, out_data, out_valid);
  modport user   (output in_data, in_valid, out_ready, input in_ready, out_data, out_valid);
endinterface

// ===== iit_bus_peer.sv
/*
  Behavioural slave on the two-wire bus: acknowledges each byte or refuses it.
  Assumes pulled-up lines; the design pulls a line low while its enable is high.
*/
`timescale 1ns/100ps
module iit_bus_peer (
  input  wire logic scl_en,
  input  wire logic sda_en,
  input  wire logic nack,
  output logic      scl_in,
  output logic      sda_in
);
  int         bits;
  logic       ack_drv;
  logic [7:0] sh;
  logic [7:0] got_q[$];
  // Released lines float to the pull-up level
  assign scl_in = !scl_en;
  assign sda_in = !(sda_en || ack_drv);
  initial begin
    bits = 0;
    ack_drv = 1'b0;
    sh = 8'h00;
  end
  // Data bits are taken while the clock is high, eight to a byte
  always @(posedge scl_in) begin
    if (bits >= 0 && bits < 8) sh = {sh[6:0], sda_in};
  end
  // Start: the clock fall just after it does not end a bit
  always @(negedge sda_in) begin
    if (scl_in) bits = -1;
  end
  // Pull data low through the ninth bit unless told to refuse
  always @(negedge scl_in) begin
    bits++;
    if (bits == 8) got_q.push_back(sh);
    ack_drv = (bits == 8) && !nack;
    if (bits == 9) bits = 0;
  end
endmodule

// ===== iit_core.sv
/*
  Bus clock timing, interrupt flags and throttling of a two-wire controller.
  Assumes the rest of the controller reports bus events as one-cycle pulses,
  the control bits arrive as levels, and all inputs are synchronous to clk.
*/
`timescale 1ns/100ps
// Overview of operation
// - SCL high phase counted from register
// - SCL low phase counted from register
// - Data held after SCL falls, counted
// - Timing registers reset to rate defaults
// - Arbitration loss raises flag zero
// - Master transmit nack: flag, drop master, stop
// - Own nack or slave last byte: flag one
// - Writing one toggles a flag bit
// - Transmit empty flag held during throttle
// - Receive fill flag cleared only by read
// - Idle flag cannot clear while bus idle
// - Own slave address sets flag five
// - Foreign address after start sets six
// - Flag seven while transmit level below half
// - Hold SCL low after acknowledge when throttled
// - Throttle by direction; stop/restart master only
// - Transmit throttle on empty, ends on write
// - Restart bit then address; throttle again
// - Receive throttle at threshold, lifted per read
// - Receive throttle: stop on drop, nack select
// - Restart under receive throttle forces transmit throttle
// - Threshold n triggers at n+1 entries
module iit_core
  import iit_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  input  wire logic                 reg_sel,
  input  wire logic                 reg_wr,
  input  wire logic [iit_pkg::AW-1:0] reg_addr,
  input  wire logic [31:0]          reg_wdata,
  output logic      [31:0]          reg_rdata,
  output logic                      reg_ack,
  input  wire logic                 master_select,
  input  wire logic                 nack_select,
  input  wire logic                 restart_request,
  input  wire logic                 tx_dir,
  input  wire logic [3:0]           rx_fill_threshold,
  input  wire logic [4:0]           rx_count,
  input  wire logic [3:0]           tx_fill_level,
  input  wire logic                 rx_read,
  input  wire logic                 bus_active_flag,
  input  wire logic                 arb_lost,
  input  wire logic                 slave_last_byte,
  input  wire logic                 slave_addr_match,
  input  wire logic                 slave_addr_miss,
  input  wire logic [7:0]           isr_toggle,
  input  wire logic [7:0]           irq_enable,
  input  wire logic [7:0]           tx_data,
  input  wire logic                 tx_valid,
  output logic                      tx_ready,
  output logic [7:0]                rx_data,
  output logic                      rx_valid,
  output logic [7:0]                interrupt_flag_register,
  output logic                      irq_out,
  output logic                      master_active,
  input  wire logic                 scl_in,
  output logic                      scl_out,
  output logic                      scl_out_en,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_out_en
);
  import iit_pkg::*;

  // ****************************************
  // Registers and internal state
  // ****************************************
  logic [31:0] scl_high_count_reg;
  logic [31:0] scl_low_count_reg;
  logic [31:0] data_hold_count_reg;
  iit_state_t  state_reg;
  logic [31:0] cnt_reg;
  logic [3:0]  bit_reg;
  logic [7:0]  shift_reg;
  logic        sda_low_reg;
  logic        scl_low_reg;
  logic        ms_dly_reg;
  logic        rx_lift_reg;
  logic        nack_ev_reg;
  logic [7:0]  isr_reg;
  logic [7:0]  isr_next;
  logic [7:0]  set_now;
  logic [7:0]  clr_ok;
  logic        tx_thr;
  logic        rx_thr;
  logic        throttle;
  logic        ack_end;
  logic        nack_seen;
  iit_buf_if   bq ();

  // ****************************************
  // Buffer in the transmit byte path
  // ****************************************
  assign bq.in_data  = tx_data;
  assign bq.in_valid = tx_valid;
  assign bq.out_ready = ce && (state_reg == IIT_START ||
                               (ack_end && tx_dir && !nack_seen && !throttle) ||
                               (state_reg == IIT_HOLD && tx_dir && !throttle &&
                                !restart_request && master_active));

  iit_buf2 u_buf (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .bp    (bq)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ready <= 1'b0;
    end else if (ce) begin
      tx_ready <= bq.in_ready;
    end
  end

  // ****************************************
  // Timing register port
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_high_count_reg  <= RST_SCL_HIGH;
      scl_low_count_reg   <= RST_SCL_LOW;
      data_hold_count_reg <= RST_DATA_HOLD;
    end else if (ce && reg_sel && reg_wr) begin
      unique case (reg_addr)
        OFF_SCL_HIGH:  scl_high_count_reg  <= reg_wdata;
        OFF_SCL_LOW:   scl_low_count_reg   <= reg_wdata;
        OFF_DATA_HOLD: data_hold_count_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
      reg_ack   <= 1'b0;
    end else if (ce) begin
      reg_ack <= reg_sel;
      if (reg_sel && !reg_wr) begin
        unique case (reg_addr)
          OFF_SCL_HIGH:  reg_rdata <= scl_high_count_reg;
          OFF_SCL_LOW:   reg_rdata <= scl_low_count_reg;
          OFF_DATA_HOLD: reg_rdata <= data_hold_count_reg;
          default:       reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************
  // Throttle conditions
  // ****************************************
  // A restart under receive throttle turns the empty queue into a transmit throttle
  assign tx_thr = (tx_dir || (restart_request && master_active)) &&
                  !bq.out_valid && master_select;
  assign rx_thr = !tx_dir && (rx_count == 5'({1'b0, rx_fill_threshold} + 5'h01)) &&
                  !rx_lift_reg;
  assign throttle = tx_thr || rx_thr;
  assign ack_end = (state_reg == IIT_HIGH) && scl_in && (cnt_reg >= scl_high_count_reg) &&
                   (bit_reg == ACK_BIT);
  assign nack_seen = tx_dir && sda_in;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_lift_reg <= 1'b0;
    end else if (ce) begin
      if (rx_read) begin
        rx_lift_reg <= 1'b1;
      end else if (ack_end) begin
        rx_lift_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Master ownership
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      master_active <= 1'b0;
      ms_dly_reg    <= 1'b0;
    end else if (ce) begin
      ms_dly_reg <= master_select;
      if (arb_lost || (ack_end && nack_seen && master_active)) begin
        master_active <= 1'b0;
      end else if (master_select && !ms_dly_reg) begin
        master_active <= 1'b1;
      end else if (!master_select && state_reg == IIT_IDLE) begin
        master_active <= 1'b0;
      end
    end
  end

  // ****************************************
  // Bus clock and data engine
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= IIT_IDLE;
      cnt_reg     <= 32'h00000000;
      bit_reg     <= 4'h0;
      shift_reg   <= 8'h00;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      nack_ev_reg <= 1'b0;
    end else if (ce) begin
      nack_ev_reg <= 1'b0;
      cnt_reg <= 32'(cnt_reg + 32'h00000001);
      unique case (state_reg)
        IIT_IDLE: begin
          scl_low_reg <= 1'b0;
          sda_low_reg <= 1'b0;
          cnt_reg     <= 32'h00000000;
          if (master_active && bq.out_valid && !bus_active_flag) begin
            state_reg <= IIT_START;
          end
        end
        IIT_START: begin
          sda_low_reg <= 1'b1;
          shift_reg   <= bq.out_data;
          bit_reg     <= 4'h0;
          cnt_reg     <= 32'h00000000;
          state_reg   <= IIT_LOW;
        end
        IIT_LOW: begin
          scl_low_reg <= 1'b1;
          if (cnt_reg == data_hold_count_reg) begin
            if (bit_reg == ACK_BIT) begin
              sda_low_reg <= !tx_dir && !nack_select;
            end else begin
              sda_low_reg <= tx_dir && !shift_reg[7];
            end
          end
          if (cnt_reg >= scl_low_count_reg) begin
            cnt_reg   <= 32'h00000000;
            state_reg <= IIT_HIGH;
          end
        end
        IIT_HIGH: begin
          scl_low_reg <= 1'b0;
          if (!scl_in) begin
            cnt_reg <= 32'h00000000;
          end else if (cnt_reg >= scl_high_count_reg) begin
            cnt_reg <= 32'h00000000;
            if (bit_reg != ACK_BIT) begin
              shift_reg <= {shift_reg[6:0], sda_in};
              bit_reg   <= 4'(bit_reg + 4'h1);
              state_reg <= IIT_LOW;
            end else begin
              bit_reg <= 4'h0;
              nack_ev_reg <= nack_seen || (!tx_dir && nack_select);
              if (nack_seen && master_active) begin
                state_reg <= IIT_STOP;
              end else if (!master_select && master_active && tx_dir && !bq.out_valid) begin
                // Last byte out with a stop pending: no throttle, just stop
                state_reg <= IIT_STOP;
              end else if (throttle) begin
                state_reg <= IIT_HOLD;
              end else begin
                if (tx_dir) begin
                  shift_reg <= bq.out_data;
                end
                state_reg <= IIT_LOW;
              end
            end
          end
        end
        IIT_HOLD: begin
          scl_low_reg <= 1'b1;
          cnt_reg     <= 32'h00000000;
          // Restarts and receive stops leave from here, and only as master
          if (!master_select && master_active && !tx_dir) begin
            state_reg <= IIT_STOP;
          end else if (restart_request && master_active && bq.out_valid) begin
            state_reg <= IIT_RS_LOW;
          end else if (!throttle && (!tx_dir || bq.out_valid)) begin
            // A pending transmit stop waits here for the last byte
            if (tx_dir) begin
              shift_reg <= bq.out_data;
            end
            state_reg <= IIT_LOW;
          end
        end
        IIT_RS_LOW: begin
          scl_low_reg <= 1'b1;
          sda_low_reg <= 1'b0;
          if (cnt_reg >= scl_low_count_reg) begin
            cnt_reg   <= 32'h00000000;
            state_reg <= IIT_RS_HIGH;
          end
        end
        IIT_RS_HIGH: begin
          scl_low_reg <= 1'b0;
          if (cnt_reg >= scl_high_count_reg) begin
            state_reg <= IIT_START;
          end
        end
        IIT_STOP: begin
          if (cnt_reg < scl_low_count_reg) begin
            scl_low_reg <= 1'b1;
            sda_low_reg <= 1'b1;
          end else if (cnt_reg < 32'(scl_low_count_reg + scl_high_count_reg)) begin
            scl_low_reg <= 1'b0;
          end else begin
            sda_low_reg <= 1'b0;
            state_reg   <= IIT_IDLE;
          end
        end
        default: state_reg <= IIT_IDLE;
      endcase
    end
  end

  // Open-drain pins: enable pulls low, data output is constant low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_out    <= 1'b0;
      scl_out_en <= 1'b0;
      sda_out    <= 1'b0;
      sda_out_en <= 1'b0;
      rx_data    <= 8'h00;
      rx_valid   <= 1'b0;
    end else if (ce) begin
      scl_out_en <= scl_low_reg;
      sda_out_en <= sda_low_reg;
      rx_valid   <= ack_end && !tx_dir;
      if (ack_end && !tx_dir) begin
        rx_data <= shift_reg;
      end
    end
  end

  // ****************************************
  // Interrupt flags
  // ****************************************
  always_comb begin
    set_now            = 8'h00;
    set_now[IRQ_ARB]   = arb_lost;
    set_now[IRQ_TXERR] = nack_ev_reg || slave_last_byte;
    set_now[IRQ_TXEMP] = tx_thr;
    set_now[IRQ_RXFUL] = rx_count == 5'({1'b0, rx_fill_threshold} + 5'h01);
    set_now[IRQ_IDLE]  = !bus_active_flag;
    set_now[IRQ_AAS]   = slave_addr_match;
    set_now[IRQ_NAS]   = slave_addr_miss;
    set_now[IRQ_HALF]  = !tx_fill_level[3];
    clr_ok             = 8'hFF;
    clr_ok[IRQ_RXFUL]  = 1'b0;
    // Set wins over a toggle in the same cycle, so no event is lost
    isr_next = (isr_reg ^ (isr_toggle & clr_ok)) | set_now;
    if (rx_read && !set_now[IRQ_RXFUL]) begin
      isr_next[IRQ_RXFUL] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      isr_reg                 <= ISR_RST;
      interrupt_flag_register <= ISR_RST;
      irq_out                 <= 1'b0;
    end else if (ce) begin
      isr_reg                 <= isr_next;
      interrupt_flag_register <= isr_next;
      irq_out                 <= |(isr_next & irq_enable);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_arb_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    ce && arb_lost |=> isr_reg[IRQ_ARB])
    else $error("arbitration loss did not set flag zero");
  a_idle_flag_stuck: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !bus_active_flag |=> isr_reg[IRQ_IDLE])
    else $error("idle flag cleared while bus idle");
  a_txemp_held: assert property (@(posedge clk) disable iff (!rst_n)
    ce && tx_thr |=> isr_reg[IRQ_TXEMP])
    else $error("transmit empty flag dropped during throttle");
  a_rxful_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    ce && isr_reg[IRQ_RXFUL] && !rx_read |=> isr_reg[IRQ_RXFUL])
    else $error("receive fill flag cleared without read");
  a_toggle_clear: assert property (@(posedge clk) disable iff (!rst_n)
    ce && isr_reg[IRQ_AAS] && isr_toggle[IRQ_AAS] && !slave_addr_match |=> !isr_reg[IRQ_AAS])
    else $error("toggle write did not clear flag five");
  a_hold_scl_low: assert property (@(posedge clk) disable iff (!rst_n)
    ce && state_reg == IIT_HOLD ##1 ce && state_reg == IIT_HOLD |=> scl_out_en)
    else $error("bus clock released during throttle");
  a_nack_stop: assert property (@(posedge clk) disable iff (!rst_n)
    ce && ack_end && nack_seen && master_active |=> state_reg == IIT_STOP && !master_active)
    else $error("master transmit nack did not stop");
  a_irq_merge: assert property (@(posedge clk) disable iff (!rst_n)
    ce |=> irq_out == |($past(isr_next) & $past(irq_enable)))
    else $error("interrupt output does not follow enabled flags");
  a_half_flag: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !tx_fill_level[3] |=> isr_reg[IRQ_HALF])
    else $error("half empty flag missing");
endmodule

// ===== iit_core_tb_top.sv
/*
  Self-checking bench: registers, flags, buffer and two transmit transfers.
  Assumes the bus peer stands on the pins and the core runs at 20 MHz.
*/
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module iit_core_tb_top;
  import iit_pkg::*;
  logic clk, rst_n, reg_sel, reg_wr, rx_read, bus_active_flag, arb_lost;
  logic sam, sas, tx_valid, tx_ready, rx_valid, irq_out, master_active;
  logic scl_in, scl_out, scl_out_en, sda_in, sda_out, sda_out_en, nack, ok;
  logic reg_ack, ms, slb, rsr, txd;
  logic [8:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [3:0]  thr, tx_lvl;
  logic [4:0]  rx_count;
  logic [7:0]  isr_toggle, irq_enable, tx_data, rx_data, flags;
  logic [7:0]  tx_b, exp_q[$];
  int          n_mismatch, checked, i, mdl[3];
  iit_core i_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .reg_sel(reg_sel), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .master_select(ms), .nack_select(1'b0), .restart_request(rsr), .tx_dir(txd),
    .rx_fill_threshold(thr), .rx_count(rx_count), .tx_fill_level(tx_lvl), .rx_read(rx_read),
    .bus_active_flag(bus_active_flag), .arb_lost(arb_lost), .slave_last_byte(slb),
    .slave_addr_match(sam), .slave_addr_miss(sas), .isr_toggle(isr_toggle),
    .irq_enable(irq_enable), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .interrupt_flag_register(flags),
    .irq_out(irq_out), .master_active(master_active), .scl_in(scl_in), .scl_out(scl_out),
    .scl_out_en(scl_out_en), .sda_in(sda_in), .sda_out(sda_out), .sda_out_en(sda_out_en));
  iit_bus_peer i_peer (.scl_en(scl_out_en), .sda_en(sda_out_en), .nack(nack),
    .scl_in(scl_in), .sda_in(sda_in));
  initial begin
    clk = 1'b0;
    forever #25 clk = !clk;
  end
  task tick();
    @(posedge clk);
    #1;
  endtask
  task wrap_up();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task rw(input logic wr, input logic [8:0] a, input logic [31:0] d);
    int k;
    reg_sel = 1'b1; reg_wr = wr; reg_addr = a; reg_wdata = d;
    tick();
    reg_sel = 1'b0;
    for (k = 0; k < 8 && reg_ack !== 1'b1; k++) tick();
    `CHK("ack", 1'b1, reg_ack)
    rd = reg_rdata;
    tick();
  endtask
  task tog(input int b);
    isr_toggle[b] = 1'b1;
    tick();
    isr_toggle = 8'h00;
    tick(); tick();
  endtask
  task push(input logic [7:0] d);
    ok = (tx_ready === 1'b1);
    if (ok) begin tx_data = d; tx_valid = 1'b1; end
    tick();
    tx_valid = 1'b0;
    tick();
  endtask
  task wait_flag(input int b);
    int k;
    for (k = 0; k < 40000 && flags[b] !== 1'b1; k++) tick();
    if (k == 40000) begin n_mismatch++; wrap_up(); end
  endtask
  task done(input string s);
    $display("test %s done", s);
  endtask
  initial begin
    n_mismatch = 0; checked = 0; rst_n = 1'b0; reg_sel = 1'b0; reg_wr = 1'b0;
    reg_addr = 9'h000; reg_wdata = 32'h0; ms = 1'b0; nack = 1'b0; thr = 4'h3;
    rx_count = 5'h00; tx_lvl = 4'h8; rx_read = 1'b0; bus_active_flag = 1'b0;
    arb_lost = 1'b0; sam = 1'b0; sas = 1'b0; isr_toggle = 8'h00; irq_enable = 8'h00;
    tx_data = 8'h00; tx_valid = 1'b0; slb = 1'b0; rsr = 1'b0; txd = 1'b1;
    rd = $urandom(64);
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    // ****************************************
    // Timing registers
    // ****************************************
    mdl = '{RST_SCL_HIGH, RST_SCL_LOW, RST_DATA_HOLD};
    for (i = 0; i < 3; i++) begin rw(0, OFF_SCL_HIGH + 9'(4 * i), 0); `CHK("rst", mdl[i], rd) end
    for (i = 0; i < 3; i++) begin mdl[i] = $urandom; rw(1, OFF_SCL_HIGH + 9'(4 * i), mdl[i]); end
    for (i = 0; i < 3; i++) begin rw(0, OFF_SCL_HIGH + 9'(4 * i), 0); `CHK("rw", mdl[i], rd) end
    rw(1, 9'h148, 32'hFFFFFFFF); rw(0, 9'h148, 0); `CHK("unmapped", 32'h0, rd)
    rw(1, OFF_SCL_HIGH, 32'hA); rw(1, OFF_SCL_LOW, 32'hA); rw(1, OFF_DATA_HOLD, 32'h3);
    done("regs");
    // ****************************************
    // Interrupt flags
    // ****************************************
    `CHK("idle", 1'b1, flags[IRQ_IDLE])
    `CHK("half", 1'b0, flags[IRQ_HALF])
    arb_lost = 1'b1; tick(); arb_lost = 1'b0; tick(); tick();
    `CHK("arb", 1'b1, flags[IRQ_ARB])
    irq_enable = 8'h01; tick(); tick();
    `CHK("irq", 1'b1, irq_out)
    tog(IRQ_ARB);
    `CHK("arbclr", 1'b0, flags[IRQ_ARB])
    `CHK("irqclr", 1'b0, irq_out)
    tog(IRQ_IDLE);
    `CHK("idlekeep", 1'b1, flags[IRQ_IDLE])
    bus_active_flag = 1'b1; tick(); tog(IRQ_IDLE);
    `CHK("idleclr", 1'b0, flags[IRQ_IDLE])
    bus_active_flag = 1'b0; tx_lvl = 4'h7; sam = 1'b1; tick(); sam = 1'b0; sas = 1'b1;
    tick(); sas = 1'b0; tick(); tick();
    `CHK("half", 1'b1, flags[IRQ_HALF])
    `CHK("aas", 1'b1, flags[IRQ_AAS])
    `CHK("nas", 1'b1, flags[IRQ_NAS])
    tog(IRQ_AAS);
    `CHK("aasclr", 1'b0, flags[IRQ_AAS])
    rx_count = 5'h03; tick(); tick();
    `CHK("rxlow", 1'b0, flags[IRQ_RXFUL])
    rx_count = 5'h04; tick(); tick(); tog(IRQ_RXFUL);
    `CHK("rxful", 1'b1, flags[IRQ_RXFUL])
    rx_count = 5'h03; rx_read = 1'b1; tick(); rx_read = 1'b0; tick(); tick();
    `CHK("rxclr", 1'b0, flags[IRQ_RXFUL])
    rx_count = 5'h00; done("flags");
    // ****************************************
    // Buffer and transmit throttle
    // ****************************************
    mdl[0] = 0;
    for (i = 0; i < 4; i++) begin
      tx_b = 8'($urandom); push(tx_b); mdl[0] += ok;
      if (ok) exp_q.push_back(tx_b);
    end
    `CHK("accepted", 2, mdl[0])
    ms = 1'b1;
    wait_flag(IRQ_TXEMP);
    // The flag rises as the queue empties; the byte in flight still goes out
    repeat (300) tick();
    for (i = 0; i < 100; i++) begin tick(); `CHK("stall", 1'b1, scl_out_en) end
    tog(IRQ_TXEMP);
    `CHK("txemp", 1'b1, flags[IRQ_TXEMP])
    `CHK("noerr", 1'b0, flags[IRQ_TXERR])
    ms = 1'b0; tick(); tx_b = 8'($urandom); push(tx_b); exp_q.push_back(tx_b);
    for (i = 0; i < 1000 && master_active !== 1'b0; i++) tick();
    `CHK("stop", 1'b0, master_active)
    `CHK("acked", 1'b0, flags[IRQ_TXERR])
    nack = 1'b1; tx_b = 8'($urandom); push(tx_b); exp_q.push_back(tx_b); ms = 1'b1;
    wait_flag(IRQ_TXERR);
    for (i = 0; i < 20 && master_active !== 1'b0; i++) tick();
    `CHK("master", 1'b0, master_active)
    `CHK("nbytes", 4, i_peer.got_q.size())
    for (i = 0; i < 4; i++) `CHK("byte", exp_q[i], i_peer.got_q[i])
    `CHK("pins", 2'b00, {scl_out, sda_out})
    `CHK("rxidle", 9'h000, {rx_valid, rx_data})
    done("throttle");
    tog(IRQ_TXERR);
    `CHK("errclr", 1'b0, flags[IRQ_TXERR])
    slb = 1'b1; tick(); slb = 1'b0; tick(); tick();
    `CHK("lastbyte", 1'b1, flags[IRQ_TXERR])
    txd = 1'b0; ms = 1'b0; tick(); tog(IRQ_TXEMP);
    `CHK("txempclr", 1'b0, flags[IRQ_TXEMP])
    rsr = 1'b1; ms = 1'b1; tick(); tick(); tick();
    `CHK("rstxthr", 1'b1, flags[IRQ_TXEMP])
    rsr = 1'b0; ms = 1'b0; txd = 1'b1;
    done("restart");
    wrap_up();
  end
endmodule

// ===== iit_pkg.sv
/*
  Constants shared by the two-wire timing, interrupt and throttle block.
  Assumes a single 20 MHz core clock and standard bus rate defaults.
*/
package iit_pkg;
  // ****************************************
  // Clock and bus rate
  // ****************************************
  localparam int unsigned CORE_HZ     = 20000000;
  localparam int unsigned BUS_RATE_HZ = 100000;
  localparam int unsigned HOLD_NS     = 300;
  localparam int unsigned CLK_NS      = 1000000000 / CORE_HZ;
  // ****************************************
  // Register port
  // ****************************************
  localparam int unsigned AW = 9;
  localparam logic [8:0] OFF_SCL_HIGH  = 9'h13C;
  localparam logic [8:0] OFF_SCL_LOW   = 9'h140;
  localparam logic [8:0] OFF_DATA_HOLD = 9'h144;
  // Defaults derive from core clock and bus rate; hold time rounds up
  localparam logic [31:0] RST_SCL_HIGH  = 32'(CORE_HZ / BUS_RATE_HZ / 2);
  localparam logic [31:0] RST_SCL_LOW   = 32'(CORE_HZ / BUS_RATE_HZ / 2);
  localparam logic [31:0] RST_DATA_HOLD = 32'((HOLD_NS + CLK_NS - 1) / CLK_NS);
  // ****************************************
  // Interrupt flag positions
  // ****************************************
  localparam int unsigned IRQ_ARB   = 0;
  localparam int unsigned IRQ_TXERR = 1;
  localparam int unsigned IRQ_TXEMP = 2;
  localparam int unsigned IRQ_RXFUL = 3;
  localparam int unsigned IRQ_IDLE  = 4;
  localparam int unsigned IRQ_AAS   = 5;
  localparam int unsigned IRQ_NAS   = 6;
  localparam int unsigned IRQ_HALF  = 7;
  localparam logic [7:0]  ISR_RST   = 8'h00;
  localparam logic [3:0]  ACK_BIT   = 4'h8;
  typedef enum logic [2:0] {
    IIT_IDLE, IIT_START, IIT_LOW, IIT_HIGH, IIT_HOLD, IIT_RS_LOW, IIT_RS_HIGH, IIT_STOP
  } iit_state_t;
endpackage
